// [bench/rbsel_host_model.sv]
// Serial host model: sends framed commands and captures returned words
`timescale 1ns/1ns
module rbsel_host_model (
    input  wire logic core_clk,
    output logic      spi_sclk,
    output logic      spi_cs_n,
    output logic      spi_sdi,
    input  wire logic spi_sdo,
    input  wire logic spi_sdo_oe_n
);
    logic [31:0] rx     [0:7];
    logic        rx_drv [0:7];
    initial begin
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
        spi_sdi  = 1'b0;
    end
    // Four core cycles a half period, 80 ns a link period
    task automatic half();
        repeat (4) @(negedge core_clk);
    endtask
    // Samples late in the high phase, well after the device shifted
    task automatic frame(input logic [31:0] cmd, input int n, input int nbits = 256);
        logic [31:0] sh;
        int          k;
        sh = cmd;
        spi_cs_n = 1'b0;
        spi_sdi = sh[31];
        half();
        for (int i = 0; i < n * 32 && i < nbits; i++) begin
            k = i / 32;
            if (i % 32 == 0) begin
                rx_drv[k] = 1'b1;
            end
            spi_sclk = 1'b1;
            half();
            rx[k][31 - i % 32] = spi_sdo;
            if (spi_sdo_oe_n !== 1'b0) begin
                rx_drv[k] = 1'b0;
            end
            spi_sclk = 1'b0;
            sh = {sh[30:0], ~sh[31]};
            spi_sdi = sh[31];
            half();
        end
        // Released line shows the inverse, never a stale bit
        spi_cs_n = 1'b1;
        spi_sdi = ~spi_sdi;
        half();
        half();
    endtask
endmodule

// [bench/test_spi_readback_burst_select.sv]
// Testbench of the readback select block
`timescale 1ns/1ns
`include "rbsel_consts.svh"
module test_spi_readback_burst_select;
    import rbsel_pkg::*;
    typedef struct {
        rbsel_addr_t ptr;
        logic        hdr;
        logic        ae;
        rbsel_mask_t mask;
        int          n;
    } rbsel_row_t;
    logic        core_clk;
    logic        reset;
    logic        spi_sclk;
    logic        spi_cs_n;
    logic        spi_sdi;
    logic        spi_sdo;
    logic        spi_sdo_oe_n;
    logic        conv_ready;
    logic        alert_flag;
    logic [3:0]  din_state;
    rbsel_addr_t rd_addr;
    rbsel_word_t rd_data;
    rbsel_word_t ctrl;
    rbsel_mask_t mask;
    logic        pend;
    int          errors;
    int          checks_done;
    int          cycles;
    rbsel_row_t  rows [6] = '{
        '{8'h3F, 1'b0, 1'b0, 10'h3FF, 4},
        '{8'h3F, 1'b0, 1'b0, 10'h000, 3},
        '{8'h42, 1'b0, 1'b0, 10'h2AA, 6},
        '{8'h40, 1'b1, 1'b0, 10'h155, 5},
        '{8'hFE, 1'b0, 1'b0, 10'h3FF, 3},
        '{8'h64, 1'b0, 1'b1, 10'h3FF, 2}
    };
    // Register file stand-in: data tied to the address asked for
    assign rd_data = {~rd_addr, rd_addr};
    rbsel_top #(
        .FRAME_BITS (`RBSEL_FRAME_BITS),
        .SPAN_BASE  (`RBSEL_SPAN_BASE)
    ) u_dut (
        .core_clk     (core_clk),
        .reset        (reset),
        .spi_sclk     (spi_sclk),
        .spi_cs_n     (spi_cs_n),
        .spi_sdi      (spi_sdi),
        .spi_sdo      (spi_sdo),
        .spi_sdo_oe_n (spi_sdo_oe_n),
        .conv_ready   (conv_ready),
        .alert_flag   (alert_flag),
        .din_state    (din_state),
        .rd_addr      (rd_addr),
        .rd_data      (rd_data)
    );
    rbsel_host_model u_host (
        .core_clk     (core_clk),
        .spi_sclk     (spi_sclk),
        .spi_cs_n     (spi_cs_n),
        .spi_sdi      (spi_sdi),
        .spi_sdo      (spi_sdo),
        .spi_sdo_oe_n (spi_sdo_oe_n)
    );
    //****************************************
    // Expected values and checks
    //****************************************
    function automatic rbsel_word_t val(rbsel_addr_t a);
        if (a == `RBSEL_CTRL_OFS) return ctrl;
        if (a == `RBSEL_MASK_OFS) return {6'h00, mask};
        return {~a, a};
    endfunction
    function automatic rbsel_addr_t nxt(rbsel_addr_t a);
        rbsel_addr_t b;
        b = a + 8'h01;
        while (b >= `RBSEL_SPAN_BASE && b < `RBSEL_SPAN_BASE + 8'h0A
               && !mask[b - `RBSEL_SPAN_BASE]) begin
            b = b + 8'h01;
        end
        return b;
    endfunction
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: word got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: drive flag got %b", $time, got);
        end
    endtask
    task automatic wr(input rbsel_addr_t a, input rbsel_word_t d);
        u_host.frame({a, d, 8'h00}, 1);
        pend = (a == `RBSEL_CTRL_OFS);
        if (a == `RBSEL_CTRL_OFS) ctrl = d & 16'h03FF;
        if (a == `RBSEL_MASK_OFS) mask = d[9:0];
    endtask
    // Harmless command: address 0x00 is never stored
    task automatic rd(input int n);
        rbsel_addr_t a;
        logic [6:0]  h;
        a = ctrl[7:0];
        u_host.frame(32'h0000_0000, n);
        for (int k = 0; k < n; k++) begin
            h = ctrl[8] ? {1'b0, conv_ready, alert_flag, din_state} : a[6:0];
            chk_word(u_host.rx[k], {1'b0, h, (ctrl[9] | pend) ? val(a) : 16'h0000, 8'h00});
            chk_bit(u_host.rx_drv[k], 1'b1);
            a = nxt(a);
        end
        pend = 1'b0;
    endtask
    task automatic do_reset();
        reset = 1'b1;
        repeat (20) @(negedge core_clk);
        reset = 1'b0;
        repeat (3) @(negedge core_clk);
        chk_bit(spi_sdo_oe_n, 1'b1);
        ctrl = `RBSEL_CTRL_RST;
        mask = `RBSEL_MASK_RST;
        pend = 1'b0;
        rd(1);
        wr(`RBSEL_CTRL_OFS, 16'h0065);
        rd(2);
        $display("test reset done");
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    //****************************************
    // Clock, timeout and main sequence
    //****************************************
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // Whole run needs about 13100 cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 60000) begin
            errors++;
            $display("mismatch at %0t: run timed out", $time);
            summarize();
        end
    end
    initial begin
        reset = 1'b1;
        conv_ready = 1'b0;
        alert_flag = 1'b0;
        din_state = 4'h0;
        errors = 0;
        checks_done = 0;
        cycles = 0;
        @(negedge core_clk);
        do_reset();
        foreach (rows[i]) begin
            conv_ready = i[0];
            alert_flag = ~i[1];
            din_state = 4'h5 + i[3:0];
            wr(`RBSEL_MASK_OFS, {6'h00, rows[i].mask});
            wr(`RBSEL_CTRL_OFS, {6'h00, rows[i].ae, rows[i].hdr, rows[i].ptr});
            rd(rows[i].n);
            $display("test row %0d done", i);
        end
        rd(2);
        wr(`RBSEL_CTRL_OFS, 16'h0010);
        rd(1);
        rd(1);
        // Cut short: the pointer write must be dropped
        u_host.frame({`RBSEL_CTRL_OFS, 16'h0220, 8'h00}, 1, 16);
        pend = 1'b0;
        rd(1);
        $display("test auto and abort done");
        do_reset();
        summarize();
    end
endmodule

// [verilog/rbsel_consts.svh]
// Constants of the readback select block: offsets, fields, reset values, counts
`ifndef RBSEL_CONSTS_SVH
`define RBSEL_CONSTS_SVH
`define RBSEL_CTRL_OFS    8'h64
`define RBSEL_MASK_OFS    8'h65
`define RBSEL_CTRL_RST    16'h0000
`define RBSEL_MASK_RST    10'h3FF
`define RBSEL_PTR_MSB     7
`define RBSEL_HDR_BIT     8
`define RBSEL_AUTO_BIT    9
`define RBSEL_MASK_BITS   10
`define RBSEL_SPAN_BASE   8'h40
`define RBSEL_FRAME_BITS  32
`define RBSEL_LAST_BIT    5'h1F
`endif

// [verilog/rbsel_pkg.sv]
// Types shared by the readback select block
package rbsel_pkg;
    typedef enum logic [1:0] {
        RBSEL_IDLE  = 2'b01,
        RBSEL_SHIFT = 2'b10
    } rbsel_state_t;
    typedef logic [7:0]  rbsel_addr_t;
    typedef logic [15:0] rbsel_word_t;
    typedef logic [9:0]  rbsel_mask_t;
endpackage

// [verilog/rbsel_regs.sv]
// Readback control and burst mask registers
`timescale 1ns/1ns
`include "rbsel_consts.svh"
module rbsel_regs (
    input  wire logic                core_clk,
    input  wire logic                reset,
    input  wire logic                wr_en,
    input  wire rbsel_pkg::rbsel_addr_t wr_addr,
    input  wire rbsel_pkg::rbsel_word_t wr_data,
    output rbsel_pkg::rbsel_addr_t   ptr_ff,
    output logic                     hdr_sel_ff,
    output logic                     auto_en_ff,
    output rbsel_pkg::rbsel_mask_t   mask_ff
);
    import rbsel_pkg::*;

    rbsel_addr_t nxt_ptr;
    logic        nxt_hdr_sel;
    logic        nxt_auto_en;
    rbsel_mask_t nxt_mask;

    always_comb begin
        nxt_ptr     = ptr_ff;
        nxt_hdr_sel = hdr_sel_ff;
        nxt_auto_en = auto_en_ff;
        nxt_mask    = mask_ff;
        if (wr_en && wr_addr == `RBSEL_CTRL_OFS) begin
            nxt_ptr     = wr_data[`RBSEL_PTR_MSB:0];
            nxt_hdr_sel = wr_data[`RBSEL_HDR_BIT];
            nxt_auto_en = wr_data[`RBSEL_AUTO_BIT];
        end
        if (wr_en && wr_addr == `RBSEL_MASK_OFS) begin
            nxt_mask = wr_data[`RBSEL_MASK_BITS-1:0];
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            ptr_ff     <= 8'(`RBSEL_CTRL_RST);
            hdr_sel_ff <= 1'b0;
            auto_en_ff <= 1'b0;
            mask_ff    <= `RBSEL_MASK_RST;
        end else begin
            ptr_ff     <= nxt_ptr;
            hdr_sel_ff <= nxt_hdr_sel;
            auto_en_ff <= nxt_auto_en;
            mask_ff    <= nxt_mask;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    property p_ptr_wr;
        wr_en && wr_addr == `RBSEL_CTRL_OFS |=> ptr_ff == $past(wr_data[7:0]);
    endproperty
    a_ptr_wr: assert property (p_ptr_wr) else $error("pointer not written");

    property p_mask_rst;
        $fell(reset) |-> mask_ff == 10'h3FF;
    endproperty
    a_mask_rst: assert property (p_mask_rst) else $error("mask reset wrong");
endmodule

// [verilog/rbsel_sync.sv]
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ns
module rbsel_sync #(
    parameter int                 WIDTH   = 1,
    parameter logic [WIDTH-1:0]   RST_VAL = '0
) (
    input  wire logic             core_clk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1_ff;

    if (WIDTH < 1) begin : g_chk
        $error("rbsel_sync needs WIDTH of at least one");
    end

    // First stage feeds only the second stage
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            stage1_ff <= RST_VAL;
            sync_out  <= RST_VAL;
        end else begin
            stage1_ff <= async_in;
            sync_out  <= stage1_ff;
        end
    end
endmodule

// [verilog/rbsel_top.sv]
// Serial readback control: pointer, frame header select, burst mask
`timescale 1ns/1ns
`include "rbsel_consts.svh"
module rbsel_top #(
    parameter int                     FRAME_BITS = `RBSEL_FRAME_BITS,
    parameter rbsel_pkg::rbsel_addr_t SPAN_BASE  = `RBSEL_SPAN_BASE
) (
    input  wire logic                   core_clk,
    input  wire logic                   reset,
    input  wire logic                   spi_sclk,
    input  wire logic                   spi_cs_n,
    input  wire logic                   spi_sdi,
    output logic                        spi_sdo,
    output logic                        spi_sdo_oe_n,
    input  wire logic                   conv_ready,
    input  wire logic                   alert_flag,
    input  wire logic [3:0]             din_state,
    output rbsel_pkg::rbsel_addr_t      rd_addr,
    input  wire rbsel_pkg::rbsel_word_t rd_data
);
    import rbsel_pkg::*;

    // ****************************************
    // Checks
    // ****************************************
    if (FRAME_BITS != 32) begin : g_frame_chk
        $error("rbsel_top serves only 32-bit frames");
    end
    if (SPAN_BASE > 8'hF6) begin : g_span_chk
        $error("rbsel_top mask span must not wrap");
    end

    // ****************************************
    // Functions
    // ****************************************
    // Maskable span is ten consecutive addresses, bit i at SPAN_BASE+i
    function automatic logic rbsel_skip(input rbsel_addr_t a, input rbsel_mask_t m);
        rbsel_addr_t ofs;
        ofs = a - SPAN_BASE;
        rbsel_skip = (a >= SPAN_BASE) && (ofs < 8'h0A) && !m[ofs[3:0]];
    endfunction

    // At most ten skips in a row, so eleven steps always find a target
    function automatic rbsel_addr_t rbsel_step(input rbsel_addr_t a, input rbsel_mask_t m);
        rbsel_addr_t c;
        logic        done;
        rbsel_step = a + 8'h01;
        done = 1'b0;
        for (int k = 1; k <= 11; k++) begin
            c = a + k[7:0];
            if (!done && !rbsel_skip(c, m)) begin
                rbsel_step = c;
                done = 1'b1;
            end
        end
    endfunction

    // ****************************************
    // Pin synchronisers and edges
    // ****************************************
    logic        sclk_s;
    logic        cs_n_s;
    logic        sdi_s;
    logic        sclk_d_ff;
    logic        sclk_rise;
    logic        sclk_fall;

    rbsel_sync #(
        .WIDTH   (3),
        .RST_VAL (3'h2)
    ) u_sync (
        .core_clk (core_clk),
        .reset    (reset),
        .async_in ({spi_sclk, spi_cs_n, spi_sdi}),
        .sync_out ({sclk_s, cs_n_s, sdi_s})
    );

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            sclk_d_ff <= 1'b0;
        end else begin
            sclk_d_ff <= sclk_s;
        end
    end
    assign sclk_rise = sclk_s & ~sclk_d_ff;
    assign sclk_fall = ~sclk_s & sclk_d_ff;

    // ****************************************
    // Registers
    // ****************************************
    logic        wr_en;
    rbsel_addr_t wr_addr;
    rbsel_word_t wr_data;
    rbsel_addr_t ptr;
    logic        hdr_sel;
    logic        auto_en;
    rbsel_mask_t mask;
    logic [31:0] in_word;

    rbsel_regs u_regs (
        .core_clk   (core_clk),
        .reset      (reset),
        .wr_en      (wr_en),
        .wr_addr    (wr_addr),
        .wr_data    (wr_data),
        .ptr_ff     (ptr),
        .hdr_sel_ff (hdr_sel),
        .auto_en_ff (auto_en),
        .mask_ff    (mask)
    );

    // ****************************************
    // Frame engine
    // ****************************************
    rbsel_state_t state_ff;
    rbsel_state_t nxt_state;
    logic [4:0]   cnt_ff;
    logic [4:0]   nxt_cnt;
    logic         first_ff;
    logic         nxt_first;
    logic [31:0]  word_ff;
    logic [31:0]  nxt_word;
    logic [30:0]  in_ff;
    logic [30:0]  nxt_in;
    logic         sdo_ff;
    logic         nxt_sdo;
    logic         oe_n_ff;
    logic         nxt_oe_n;
    rbsel_addr_t  rd_addr_ff;
    rbsel_addr_t  nxt_rd_addr;
    logic         rd_on_ff;
    logic         nxt_rd_on;
    logic         pend_ff;
    logic         nxt_pend;
    logic         start;
    logic         load;
    logic         data_on;
    logic [6:0]   hdr;
    rbsel_word_t  rd_value;
    logic [31:0]  frame_word;

    assign in_word = {in_ff, sdi_s};
    assign wr_addr = in_word[31:24];
    assign wr_data = in_word[23:8];
    assign start   = (state_ff == RBSEL_IDLE) && !cs_n_s;
    // Data field is live under auto mode or right after a pointer write
    assign data_on = start ? (auto_en | pend_ff) : rd_on_ff;

    always_comb begin
        rd_value = rd_data;
        if (rd_addr_ff == `RBSEL_CTRL_OFS) begin
            rd_value = {6'h00, auto_en, hdr_sel, ptr};
        end else if (rd_addr_ff == `RBSEL_MASK_OFS) begin
            rd_value = {6'h00, mask};
        end
        if (hdr_sel) begin
            hdr = {1'b0, conv_ready, alert_flag, din_state};
        end else begin
            hdr = rd_addr_ff[6:0];
        end
        frame_word = {1'b0, hdr, (data_on ? rd_value : 16'h0000), 8'h00};
    end

    always_comb begin
        nxt_state   = state_ff;
        nxt_cnt     = cnt_ff;
        nxt_first   = first_ff;
        nxt_word    = word_ff;
        nxt_in      = in_ff;
        nxt_sdo     = sdo_ff;
        nxt_oe_n    = oe_n_ff;
        nxt_rd_addr = rd_addr_ff;
        nxt_rd_on   = rd_on_ff;
        nxt_pend    = pend_ff;
        wr_en       = 1'b0;
        load        = 1'b0;
        unique case (state_ff)
            RBSEL_IDLE: begin
                nxt_oe_n    = 1'b1;
                nxt_rd_addr = ptr;
                if (start) begin
                    // First word always comes from the pointer, masked or not
                    load        = 1'b1;
                    nxt_state   = RBSEL_SHIFT;
                    nxt_word    = frame_word;
                    nxt_sdo     = frame_word[31];
                    nxt_oe_n    = 1'b0;
                    nxt_cnt     = 5'h00;
                    nxt_first   = 1'b1;
                    nxt_rd_on   = data_on;
                    nxt_pend    = 1'b0;
                    nxt_rd_addr = rbsel_step(rd_addr_ff, mask);
                end
            end
            RBSEL_SHIFT: begin
                if (cs_n_s) begin
                    // Early release drops the partial command word
                    nxt_state   = RBSEL_IDLE;
                    nxt_oe_n    = 1'b1;
                    nxt_rd_addr = ptr;
                end else if (sclk_rise) begin
                    nxt_in = in_word[30:0];
                    if (cnt_ff == `RBSEL_LAST_BIT) begin
                        nxt_cnt   = 5'h00;
                        nxt_first = 1'b0;
                        // Only the first word of a frame is a command
                        if (first_ff) begin
                            wr_en = 1'b1;
                            if (wr_addr == `RBSEL_CTRL_OFS) begin
                                nxt_pend = 1'b1;
                            end
                            // Mask change mid-frame: re-aim the rest of the burst
                            if (wr_addr == `RBSEL_MASK_OFS) begin
                                nxt_rd_addr = rbsel_step(ptr, wr_data[`RBSEL_MASK_BITS-1:0]);
                            end
                        end
                    end else begin
                        nxt_cnt = cnt_ff + 5'h01;
                    end
                end else if (sclk_fall) begin
                    if (cnt_ff == 5'h00 && !first_ff) begin
                        // Burst continues with next returned address
                        load        = 1'b1;
                        nxt_word    = frame_word;
                        nxt_sdo     = frame_word[31];
                        nxt_rd_addr = rbsel_step(rd_addr_ff, mask);
                    end else begin
                        nxt_sdo = word_ff[5'h1F - cnt_ff];
                    end
                end
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state_ff   <= RBSEL_IDLE;
            cnt_ff     <= 5'h00;
            first_ff   <= 1'b0;
            word_ff    <= 32'h00000000;
            in_ff      <= 31'h00000000;
            sdo_ff     <= 1'b0;
            oe_n_ff    <= 1'b1;
            rd_addr_ff <= 8'h00;
            rd_on_ff   <= 1'b0;
            pend_ff    <= 1'b0;
        end else begin
            state_ff   <= nxt_state;
            cnt_ff     <= nxt_cnt;
            first_ff   <= nxt_first;
            word_ff    <= nxt_word;
            in_ff      <= nxt_in;
            sdo_ff     <= nxt_sdo;
            oe_n_ff    <= nxt_oe_n;
            rd_addr_ff <= nxt_rd_addr;
            rd_on_ff   <= nxt_rd_on;
            pend_ff    <= nxt_pend;
        end
    end

    assign spi_sdo      = sdo_ff;
    assign spi_sdo_oe_n = oe_n_ff;
    assign rd_addr      = rd_addr_ff;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    property p_auto;
        start && auto_en |=> word_ff[23:8] == $past(rd_value);
    endproperty
    a_auto: assert property (p_auto) else $error("auto data missing");

    property p_hdr_ptr;
        load && !hdr_sel |=> word_ff[30:24] == $past(rd_addr_ff[6:0]);
    endproperty
    a_hdr_ptr: assert property (p_hdr_ptr) else $error("header not address");

    property p_hdr_stat;
        load && hdr_sel |=> word_ff[30:24] == $past({1'b0, conv_ready, alert_flag, din_state});
    endproperty
    a_hdr_stat: assert property (p_hdr_stat) else $error("header not status");

    property p_skip;
        load && state_ff == RBSEL_SHIFT |-> !rbsel_skip(rd_addr_ff, mask);
    endproperty
    a_skip: assert property (p_skip) else $error("masked word sent");

    property p_plain_next;
        load && !rbsel_skip(8'(rd_addr_ff + 8'h01), mask) && !cs_n_s
            |=> rd_addr_ff == 8'($past(rd_addr_ff) + 8'h01);
    endproperty
    a_plain_next: assert property (p_plain_next) else $error("unmasked skipped");

    property p_start;
        start |-> rd_addr_ff == ptr;
    endproperty
    a_start: assert property (p_start) else $error("burst start wrong");

    property p_shift;
        state_ff == RBSEL_SHIFT && !cs_n_s && sclk_fall && cnt_ff != 5'h00
            |=> spi_sdo == $past(word_ff[5'h1F - cnt_ff]);
    endproperty
    a_shift: assert property (p_shift) else $error("sdo bit wrong");

    property p_release;
        state_ff == RBSEL_SHIFT && cs_n_s |=> spi_sdo_oe_n ##1 state_ff == RBSEL_IDLE;
    endproperty
    a_release: assert property (p_release) else $error("sdo not released");

    c_burst: cover property (load && state_ff == RBSEL_SHIFT);
    c_write: cover property (wr_en && wr_addr == `RBSEL_MASK_OFS);
    c_jump:  cover property (load && state_ff == RBSEL_SHIFT ##1 rd_addr_ff != $past(rd_addr_ff) + 8'h01);
endmodule
